/* File: rtl/air_pkg.sv */
// Package for the accelerometer interrupt routing block.
// Assumes an 8-bit register port with internal addresses from the device's register interface.
package air_pkg;
    localparam logic [7:0] AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG = 8'h2C;
    localparam logic [7:0] AIR_OFS_INTERRUPT_ENABLE_MAP = 8'h2D;
    localparam logic [7:0] AIR_OFS_INTERRUPT_PIN_ROUTING = 8'h2E;
    localparam logic [7:0] AIR_OFS_INT_SOURCE = 8'h0C;
    localparam logic [7:0] AIR_RST_CONFIG = 8'h00;
    localparam logic [7:0] AIR_RST_ENABLE = 8'h00;
    localparam logic [7:0] AIR_RST_ROUTING = 8'h00;
    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] AIR_CONFIG_MASK = 8'h7B;
    localparam logic [7:0] AIR_SOURCE_MASK = 8'hBD;
    // Bit positions in the configuration register.
    localparam int AIR_BIT_WAKE_TRANSIENT = 6;
    localparam int AIR_BIT_WAKE_ORIENT = 5;
    localparam int AIR_BIT_WAKE_PULSE = 4;
    localparam int AIR_BIT_WAKE_FALL = 3;
    localparam int AIR_BIT_LEVEL = 1;
    localparam int AIR_BIT_DRIVE = 0;
    // Source positions shared by the enable, routing and source registers.
    localparam int AIR_SRC_SLEEP = 7;
    localparam int AIR_SRC_TRANSIENT = 5;
    localparam int AIR_SRC_ORIENT = 4;
    localparam int AIR_SRC_PULSE = 3;
    localparam int AIR_SRC_FALL = 2;
    localparam int AIR_SRC_READY = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } air_reg_req_t;

    typedef struct packed {
        logic o;
        logic oe;
    } air_pad_t;
endpackage

/* File: rtl/air_pad_drive.sv */
// Drives one interrupt pad from its asserted state, level and drive mode.
// Assumes the pad cell resolves the wire from output and enable.
`timescale 1ns/1ns
`default_nettype none
module air_pad_drive
    import air_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic active,
    input wire logic level_high,
    input wire logic open_drain,
    output var air_pad_t pad
);
    always_ff @(posedge clk) begin
        if (srst) begin
            // Reset polarity is active low, so the idle pad sits high.
            pad.o <= 1'b1;
            pad.oe <= 1'b1;
        end else if (open_drain) begin
            // Open drain pulls low to assert and releases otherwise.
            pad.o <= 1'b0;
            pad.oe <= active;
        end else begin
            pad.o <= active ? level_high : ~level_high;
            pad.oe <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/air_top.sv */
// Interrupt routing, pad configuration and wake selection of a three-axis accelerometer.
// Assumes detection blocks give level event flags on clk and a register port on the same clock.
// How it works
// - Transient events wake the device only when their wake bit is set.
// - Orientation events wake the device only when their wake bit is set.
// - Pulse events wake the device only when their wake bit is set.
// - Freefall or motion events wake the device only when their wake bit is set.
// - Level bit picks low or high asserted pin level in push-pull; open drain always pulls low to assert; reset is low.
// - Drive bit picks push-pull when clear, open drain when set.
// - Disabled sources never reach either interrupt pin.
// - Enable register holds one reset-clear bit per source at fixed positions.
// - Routing bit zero sends a source to pin two, one to pin one.
// - Routing bits use the enable layout; bits six and one unused.
// - Each pin asserts on the OR of its enabled routed active sources.
// - Sleep to wake and wake to sleep changes raise the sleep interrupt.
// - Sleep change and data ready never wake or keep the device awake.
`timescale 1ns/1ns
`default_nettype none
module air_top
    import air_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire air_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] event_flags,
    input wire logic sleeping,
    output logic wake_request,
    output air_pad_t irq_pin_first,
    output air_pad_t irq_pin_second
);
    logic [7:0] config_q;
    logic [7:0] enable_q;
    logic [7:0] routing_q;
    logic sleeping_q;
    logic sleep_change_q;
    logic [7:0] src_now;
    logic [7:0] gated;
    logic first_active;
    logic second_active;

    function automatic logic [7:0] air_keep(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction

    // Register writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            config_q <= AIR_RST_CONFIG;
            enable_q <= AIR_RST_ENABLE;
            routing_q <= AIR_RST_ROUTING;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG: config_q <= air_keep(reg_req.wdata, AIR_CONFIG_MASK);
                AIR_OFS_INTERRUPT_ENABLE_MAP: enable_q <= air_keep(reg_req.wdata, AIR_SOURCE_MASK);
                AIR_OFS_INTERRUPT_PIN_ROUTING: routing_q <= air_keep(reg_req.wdata, AIR_SOURCE_MASK);
                default: ;
            endcase
        end
    end

    // Sleep change event: a one-cycle flag on each change of the sleep state.
    always_ff @(posedge clk) begin
        if (srst) begin
            sleeping_q <= 1'b0;
            sleep_change_q <= 1'b0;
        end else begin
            sleeping_q <= sleeping;
            sleep_change_q <= sleeping ^ sleeping_q;
        end
    end

    always_comb begin
        src_now = air_keep(event_flags, AIR_SOURCE_MASK);
        src_now[AIR_SRC_SLEEP] = sleep_change_q;
        gated = src_now & enable_q;
        first_active = |(gated & routing_q);
        second_active = |(gated & ~routing_q);
    end

    // Read data and wake request.
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            wake_request <= 1'b0;
        end else begin
            case (reg_req.addr)
                AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG: reg_rdata <= config_q;
                AIR_OFS_INTERRUPT_ENABLE_MAP: reg_rdata <= enable_q;
                AIR_OFS_INTERRUPT_PIN_ROUTING: reg_rdata <= routing_q;
                AIR_OFS_INT_SOURCE: reg_rdata <= gated;
                default: reg_rdata <= 8'h00;
            endcase
            // Only the four detection functions count here, never sleep change or data ready.
            wake_request <= sleeping &
                ((config_q[AIR_BIT_WAKE_TRANSIENT] & gated[AIR_SRC_TRANSIENT]) |
                 (config_q[AIR_BIT_WAKE_ORIENT] & gated[AIR_SRC_ORIENT]) |
                 (config_q[AIR_BIT_WAKE_PULSE] & gated[AIR_SRC_PULSE]) |
                 (config_q[AIR_BIT_WAKE_FALL] & gated[AIR_SRC_FALL]));
        end
    end

    air_pad_drive u_pad_first (
        .clk(clk),
        .srst(srst),
        .active(first_active),
        .level_high(config_q[AIR_BIT_LEVEL]),
        .open_drain(config_q[AIR_BIT_DRIVE]),
        .pad(irq_pin_first)
    );

    air_pad_drive u_pad_second (
        .clk(clk),
        .srst(srst),
        .active(second_active),
        .level_high(config_q[AIR_BIT_LEVEL]),
        .open_drain(config_q[AIR_BIT_DRIVE]),
        .pad(irq_pin_second)
    );

    chk_disabled_silent: assert property (@(posedge clk) disable iff (srst)
        (enable_q == 8'h00) |=> !irq_pin_first.oe ||
        (!$past(config_q[AIR_BIT_DRIVE]) && irq_pin_first.o != $past(config_q[AIR_BIT_LEVEL])))
        else $error("disabled sources drove pin one");
    chk_first_or: assert property (@(posedge clk) disable iff (srst)
        (|(gated & routing_q) && !config_q[AIR_BIT_DRIVE] && $stable(config_q)) |=>
        irq_pin_first.o == $past(config_q[AIR_BIT_LEVEL]))
        else $error("pin one not asserted");
    chk_second_or: assert property (@(posedge clk) disable iff (srst)
        (|(gated & ~routing_q) && !config_q[AIR_BIT_DRIVE] && $stable(config_q)) |=>
        irq_pin_second.o == $past(config_q[AIR_BIT_LEVEL]))
        else $error("pin two not asserted");
    chk_idle_level: assert property (@(posedge clk) disable iff (srst)
        (gated == 8'h00 && !config_q[AIR_BIT_DRIVE] && $stable(config_q)) |=>
        irq_pin_first.o != $past(config_q[AIR_BIT_LEVEL]) && irq_pin_second.o != $past(config_q[AIR_BIT_LEVEL]))
        else $error("idle pin asserted");
    chk_open_release: assert property (@(posedge clk) disable iff (srst)
        (config_q[AIR_BIT_DRIVE] && $stable(config_q) && gated == 8'h00) |=> !irq_pin_first.oe && !irq_pin_second.oe)
        else $error("open drain pin not released");
    chk_wake_transient: assert property (@(posedge clk) disable iff (srst)
        (sleeping && !config_q[AIR_BIT_WAKE_TRANSIENT] && event_flags == 8'h20) |=> !wake_request)
        else $error("transient woke device while bypassed");
    chk_wake_pulse: assert property (@(posedge clk) disable iff (srst)
        (sleeping && config_q[AIR_BIT_WAKE_PULSE] && gated[AIR_SRC_PULSE]) |=> wake_request)
        else $error("pulse failed to wake device");
    chk_ready_no_wake: assert property (@(posedge clk) disable iff (srst)
        ((gated & 8'h7C) == 8'h00) |=> !wake_request)
        else $error("non-detection source woke device");
    chk_sleep_change: assert property (@(posedge clk) disable iff (srst)
        (sleeping != $past(sleeping) && !$past(srst)) |=>
        sleep_change_q ##1 (!sleep_change_q || $past(sleeping) != $past(sleeping, 2)))
        else $error("sleep change event missing");
    chk_reset_clear: assert property (@(posedge clk)
        $past(srst) |-> enable_q == AIR_RST_ENABLE && routing_q == AIR_RST_ROUTING && config_q == AIR_RST_CONFIG)
        else $error("registers not at reset values after reset");
    chk_wake_orient: assert property (@(posedge clk) disable iff (srst)
        (sleeping && !config_q[AIR_BIT_WAKE_ORIENT] && event_flags == 8'h10) |=>
        !wake_request)
        else $error("orientation woke device while bypassed");
    chk_orient_wakes: assert property (@(posedge clk) disable iff (srst)
        (sleeping && config_q[AIR_BIT_WAKE_ORIENT] && gated[AIR_SRC_ORIENT]) |=>
        wake_request)
        else $error("orientation failed to wake device");
    chk_pulse_bypass: assert property (@(posedge clk) disable iff (srst)
        (sleeping && !config_q[AIR_BIT_WAKE_PULSE] && event_flags == 8'h08) |=>
        !wake_request)
        else $error("pulse woke device while bypassed");
    chk_fall_bypass: assert property (@(posedge clk) disable iff (srst)
        (sleeping && !config_q[AIR_BIT_WAKE_FALL] && event_flags == 8'h04) |=>
        !wake_request)
        else $error("fall or motion woke device while bypassed");
    chk_fall_wakes: assert property (@(posedge clk) disable iff (srst)
        (sleeping && config_q[AIR_BIT_WAKE_FALL] && gated[AIR_SRC_FALL]) |=>
        wake_request)
        else $error("fall or motion failed to wake device");
    chk_transient_wakes: assert property (@(posedge clk) disable iff (srst)
        (sleeping && config_q[AIR_BIT_WAKE_TRANSIENT] && gated[AIR_SRC_TRANSIENT]) |=>
        wake_request)
        else $error("transient failed to wake device");
    chk_awake_quiet: assert property (@(posedge clk) disable iff (srst)
        !sleeping |=>
        !wake_request)
        else $error("wake request while awake");
    chk_disabled_second: assert property (@(posedge clk) disable iff (srst)
        (enable_q == 8'h00) |=> !irq_pin_second.oe ||
        (!$past(config_q[AIR_BIT_DRIVE]) && irq_pin_second.o != $past(config_q[AIR_BIT_LEVEL])))
        else $error("disabled sources drove pin two");
    chk_enable_unused: assert property (@(posedge clk) disable iff (srst)
        (enable_q & ~AIR_SOURCE_MASK) == 8'h00)
        else $error("unused enable bit set");
    chk_routing_unused: assert property (@(posedge clk) disable iff (srst)
        (routing_q & ~AIR_SOURCE_MASK) == 8'h00)
        else $error("unused routing bit set");
    chk_open_assert: assert property (@(posedge clk) disable iff (srst)
        (config_q[AIR_BIT_DRIVE] && first_active) |=>
        irq_pin_first.oe && !irq_pin_first.o)
        else $error("open drain pin not pulled low");
    chk_push_pull: assert property (@(posedge clk) disable iff (srst)
        !config_q[AIR_BIT_DRIVE] |=>
        irq_pin_first.oe && irq_pin_second.oe)
        else $error("push pull pin not driven");
    chk_level_high: assert property (@(posedge clk) disable iff (srst)
        (config_q[AIR_BIT_LEVEL] && !config_q[AIR_BIT_DRIVE] && second_active) |=>
        irq_pin_second.o)
        else $error("active high pin not high");
    chk_level_low: assert property (@(posedge clk) disable iff (srst)
        (!config_q[AIR_BIT_LEVEL] && !config_q[AIR_BIT_DRIVE] && first_active) |=>
        !irq_pin_first.o)
        else $error("active low pin not low");
    chk_sleep_pulse: assert property (@(posedge clk) disable iff (srst)
        sleep_change_q |=>
        !sleep_change_q || $past(sleeping) != $past(sleeping, 2))
        else $error("sleep change event too long");


    cov_first_asserted: cover property (@(posedge clk) disable iff (srst) first_active ##1 irq_pin_first.oe);
    cov_open_drain: cover property (@(posedge clk) disable iff (srst) config_q[AIR_BIT_DRIVE] && first_active);
    cov_wake: cover property (@(posedge clk) disable iff (srst) wake_request);
    cov_sleep_irq: cover property (@(posedge clk) disable iff (srst) gated[AIR_SRC_SLEEP]);
    cov_second_asserted: cover property (@(posedge clk) disable iff (srst) second_active ##1 irq_pin_second.oe);
endmodule
`default_nettype wire

/* File: testbench/air_host_model.sv */
// Host side model of the two interrupt lines as the processor sees them.
// Assumes a pull-up on each line, so a released pad reads high.
`timescale 1ns/1ns
`default_nettype none
module air_host_model
    import air_pkg::*;
(
    input wire air_pad_t pin_first,
    input wire air_pad_t pin_second,
    input wire logic level_high,
    output logic seen_first,
    output logic seen_second
);
    // A released line floats to the pull-up, which lets several pads share one line.
    // In push-pull modes the bench compares both seen lines with the expected pin states.
    assign seen_first = (pin_first.oe ? pin_first.o : 1'h1) == level_high;
    assign seen_second = (pin_second.oe ? pin_second.o : 1'h1) == level_high;
endmodule
`default_nettype wire

/* File: testbench/air_top_test.sv */
// Bench for the interrupt routing block: registers, routing, pad levels, wake and sleep change.
// Assumes the host model resolves the pads; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module air_top_test
    import air_pkg::*;
;
    logic clk, srst, sleeping, wake_request, seen_first, seen_second, lvl, od;
    logic [7:0] reg_rdata, event_flags;
    air_reg_req_t reg_req;
    air_pad_t irq_pin_first, irq_pin_second;
    int err_count = 0, compares = 0, cycles = 0, n;
    int srcs[5] = '{5, 4, 3, 2, 0};
    air_top i_dut (.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .event_flags(event_flags),
        .sleeping(sleeping), .wake_request(wake_request), .irq_pin_first(irq_pin_first),
        .irq_pin_second(irq_pin_second));
    air_host_model i_host (.pin_first(irq_pin_first), .pin_second(irq_pin_second), .level_high(lvl),
        .seen_first(seen_first), .seen_second(seen_second));
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req = '{1'h1, 1'h0, a, d};
        @(negedge clk);
        reg_req.wr = 1'h0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_req.addr = a;
        @(negedge clk);
        check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic pins(input logic a1, input logic a2);
        repeat (2) @(negedge clk);
        check("pin_first", {6'h0, irq_pin_first}, {6'h0, od ? {1'h0, a1} : {a1 ~^ lvl, 1'h1}});
        check("pin_second", {6'h0, irq_pin_second}, {6'h0, od ? {1'h0, a2} : {a2 ~^ lvl, 1'h1}});
        if (!od) check("host_seen", {6'h0, seen_first, seen_second}, {6'h0, a1, a2});
    endtask
    initial begin
        srst = 1'h1;
        sleeping = 1'h0;
        event_flags = 8'h00;
        reg_req = '0;
        lvl = 1'h0;
        od = 1'h0;
        repeat (6) @(negedge clk);
        srst = 1'h0;
        pins(1'h0, 1'h0);
        for (int a = 8'h2C; a <= 8'h2E; a++) begin
            rd(8'(a), 8'h00);
            wr(8'(a), 8'hFF);
            rd(8'(a), a == 8'h2C ? 8'h7B : 8'hBD);
        end
        rd(8'h10, 8'h00);
        for (int m = 0; m < 4; m++) begin
            {lvl, od} = 2'(m);
            wr(AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG, {6'h0, lvl, od});
            for (int i = 0; i < 5; i++) begin
                n = srcs[i];
                wr(AIR_OFS_INTERRUPT_ENABLE_MAP, 8'h01 << n);
                for (int r = 0; r < 2; r++) begin
                    wr(AIR_OFS_INTERRUPT_PIN_ROUTING, 8'(r) << n);
                    event_flags = 8'h01 << n;
                    pins(r[0], !r[0]);
                    rd(AIR_OFS_INT_SOURCE, 8'h01 << n);
                    event_flags = 8'h3D ^ (8'h01 << n);
                    pins(1'h0, 1'h0);
                end
            end
            wr(AIR_OFS_INTERRUPT_ENABLE_MAP, 8'h3D);
            wr(AIR_OFS_INTERRUPT_PIN_ROUTING, 8'h24);
            event_flags = 8'h24;
            pins(1'h1, 1'h0);
            event_flags = 8'h19;
            pins(1'h0, 1'h1);
        end
        lvl = 1'h0;
        od = 1'h0;
        sleeping = 1'h1;
        for (int i = 0; i < 4; i++) begin
            event_flags = 8'h20 >> i;
            wr(AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG, 8'h00);
            repeat (2) @(negedge clk);
            check("wake_request", {7'h0, wake_request}, 8'h00);
            wr(AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG, 8'h40 >> i);
            repeat (2) @(negedge clk);
            check("wake_request", {7'h0, wake_request}, 8'h01);
        end
        event_flags = 8'h81;
        wr(AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG, 8'h78);
        repeat (2) @(negedge clk);
        check("wake_request", {7'h0, wake_request}, 8'h00);
        event_flags = 8'h3C;
        wr(AIR_OFS_INTERRUPT_ENABLE_MAP, 8'h80);
        wr(AIR_OFS_INTERRUPT_PIN_ROUTING, 8'h80);
        check("wake_request", {7'h0, wake_request}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            sleeping = !sleeping;
            n = 0;
            repeat (5) begin
                @(negedge clk);
                n += (irq_pin_first.o === 1'h0);
            end
            check("sleep_pulses", 8'(n), 8'h01);
        end
        sleeping = 1'h0;
        srst = 1'h1;
        pins(1'h0, 1'h0);
        srst = 1'h0;
        rd(AIR_OFS_SLEEP_WAKE_AND_PAD_CONFIG, AIR_RST_CONFIG);
        rd(AIR_OFS_INTERRUPT_ENABLE_MAP, AIR_RST_ENABLE);
        rd(AIR_OFS_INTERRUPT_PIN_ROUTING, AIR_RST_ROUTING);
        pins(1'h0, 1'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
